// ===== common/csu_pkg.sv
// constants, types and helpers of the clock startup supervisor
// assumes a single 250 MHz system clock; oscillator and analog inputs arrive synchronous to it
package csu_pkg;
   localparam int CLK_MHZ        = 250;
   localparam int CLK_PERIOD_NS  = 4;
   localparam int RC_MHZ         = 8;
   localparam int EXT_MIN_MHZ    = 4;
   localparam int EXT_MAX_MHZ    = 24;
   localparam int DOMAIN_MAX_MHZ = 24;
   // external clock declared dead after two of its slowest periods without an edge
   localparam int FAIL_TIME_NS   = 2 * 1000 / EXT_MIN_MHZ;
   localparam int FAIL_CYC       = (FAIL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // core reset stays asserted this long after the supply comes good
   localparam int POR_HOLD_NS    = 1000;
   localparam int POR_HOLD_CYC   = (POR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam logic [7:0] RC_STEP     = 8'(RC_MHZ);
   localparam logic [7:0] RC_WRAP     = 8'(CLK_MHZ);
   localparam logic [7:0] MON_LIMIT   = 8'(FAIL_CYC - 1);
   localparam logic [8:0] HOLD_LIMIT  = 9'(POR_HOLD_CYC - 1);
   localparam logic       SEL_RESET   = 1'b0;
   localparam logic       CORE_RST_ON = 1'b1;
   localparam logic [9:0] DIV_RESET   = 10'h000;

   typedef enum logic [1:0] {
      BOOT_FLASH  = 2'h0,
      BOOT_SYSMEM = 2'h1,
      BOOT_SRAM   = 2'h2
   } csu_boot_t;

   typedef enum logic [1:0] {
      SW_RC     = 2'b00,
      SW_TO_EXT = 2'b01,
      SW_EXT    = 2'b11,
      SW_TO_RC  = 2'b10
   } csu_sw_state_t;

   typedef struct packed {
      logic       ext_req;     // software asks for the external clock
      logic       css_ie;      // clock failure interrupt enable
      logic       pll_ie;      // pll lock gained / lost interrupt enable
      logic       det_fall_ie; // supply dropped below detector threshold
      logic       det_rise_ie; // supply rose above detector threshold
      logic [3:0] ahb_div;     // 0xxx: /1, 1nnn: /2^(nnn+1)
      logic [2:0] apb2_div;    // 0xx: /1, 1nn: /2^(nn+1)
      logic [2:0] apb1_div;
   } csu_cfg_t;

   typedef struct packed {
      logic css_fail;
      logic pll_rdy;
      logic pll_lost;
      logic det_fall;
      logic det_rise;
   } csu_flags_t;

   // terminal count of a prescaler for a divide code
   function automatic logic [9:0] csu_div_limit(input logic [3:0] code);
      logic [10:0] span;
      span = 11'h002 << code[2:0];
      return code[3] ? 10'(span - 11'h001) : DIV_RESET;
   endfunction : csu_div_limit

   function automatic csu_boot_t csu_boot_decode(input logic [1:0] pins);
      if (!pins[0]) begin
         return BOOT_FLASH;
      end
      return pins[1] ? BOOT_SRAM : BOOT_SYSMEM;
   endfunction : csu_boot_decode
endpackage : csu_pkg

// ===== hw/csu_clk_switch.sv
// source switch between the rc tick stream and the external tick stream
// assumes tick inputs are one-cycle pulses no faster than 24 MHz
`timescale 1ns/100ps
module csu_clk_switch
   import csu_pkg::*;
(
   input  wire logic clock,      // system clock
   input  wire logic rst,        // async reset, high
   input  wire logic rc_tick,    // internal rc tick
   input  wire logic ext_tick,   // external clock rising edge
   input  wire logic want_ext,   // run from external clock
   output logic      sel_ext_q,  // external clock selected until the rc handoff ends
   output logic      sys_tick_q  // system clock tick
);
   csu_sw_state_t st_q, st_d;
   logic          seen_q, seen_d;
   logic          tick_d;

   // old source is stopped first; the first tick of the new source only aligns, the second is passed
   always_comb begin
      st_d   = st_q;
      seen_d = seen_q;
      tick_d = 1'b0;
      case (st_q)
         SW_RC: begin
            tick_d = rc_tick;
            if (want_ext) begin
               st_d   = SW_TO_EXT;
               seen_d = 1'b0;
            end
         end
         SW_TO_EXT: begin
            if (!want_ext) begin
               st_d   = SW_TO_RC;
               seen_d = 1'b0;
            end else if (ext_tick) begin
               seen_d = 1'b1;
               if (seen_q) begin
                  st_d   = SW_EXT;
                  tick_d = 1'b1;
               end
            end
         end
         SW_EXT: begin
            tick_d = ext_tick;
            if (!want_ext) begin
               st_d   = SW_TO_RC;
               seen_d = 1'b0;
            end
         end
         SW_TO_RC: begin
            if (rc_tick) begin
               seen_d = 1'b1;
               if (seen_q) begin
                  st_d   = SW_RC;
                  tick_d = 1'b1;
               end
            end
         end
         default: begin
            st_d = SW_RC;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_q       <= SW_RC;
         seen_q     <= 1'b0;
         sel_ext_q  <= SEL_RESET;
         sys_tick_q <= 1'b0;
      end else begin
         st_q       <= st_d;
         seen_q     <= seen_d;
         // high from the first passed external tick, or from an aborted switch to it, until the second rc tick of the handoff
         sel_ext_q  <= st_d[1];
         sys_tick_q <= tick_d;
      end
   end

   a_no_runt_tick: assert property (@(posedge clock) disable iff (rst)
      sys_tick_q |=> !sys_tick_q [*8])
      else $error("system tick closer than a full source period");

   a_fallback_bound: assert property (@(posedge clock) disable iff (rst)
      (sel_ext_q && !want_ext) |-> ##[1:80] !sel_ext_q)
      else $error("fallback to rc did not complete in time");
endmodule : csu_clk_switch

// ===== hw/csu_top.sv
// clock startup supervisor: source select, clock monitor, prescalers, boot select, supply supervisor
// assumes all inputs synchronous to clock; supply comparators are outside and give levels
//
// Contract
// - every reset selects the internal 8 MHz rc source
// - software may select the 4-24 MHz external clock; it is monitored while selected
// - on external clock failure hardware falls back to the rc source
// - clock failure raises the interrupt only when its enable is set
// - pll lock gained and lost produce interrupt events
// - prescalers derive ahb, apb2 and apb1 ticks, none above 24 MHz
// - boot pins sampled at startup pick flash, system memory or sram
// - core reset held while supply is below the reset threshold
// - supply level detector crossings raise interrupt events
`timescale 1ns/100ps
module csu_top
   import csu_pkg::*;
(
   input  wire logic       clock,       // 250 MHz system clock
   input  wire logic       rst,         // async reset, high
   input  wire csu_cfg_t   cfg,         // software configuration
   input  wire csu_flags_t clr,         // one-cycle flag clears
   input  wire logic       ext_clk_in,  // external clock level, sampled
   input  wire logic       pll_lock,    // pll locked level
   input  wire logic       supply_ok,   // supply above reset_supply_threshold
   input  wire logic       below_thr,   // supply below detector_threshold
   input  wire logic [1:0] boot_pins,   // boot select pins
   output logic            sys_tick_q,  // system clock tick
   output logic            ahb_tick_q,  // ahb domain tick
   output logic            apb2_tick_q, // apb2 domain tick
   output logic            apb1_tick_q, // apb1 domain tick
   output logic            sel_ext_q,   // external clock in use
   output csu_boot_t       boot_src_q,  // chosen boot source
   output logic            boot_vld_q,  // boot source captured
   output logic            core_rst_q,  // reset to the core, high
   output csu_flags_t      flags_q,     // sticky event flags
   output logic            irq_q        // combined enabled events
);
   // one prescaler step: returns {tick, next count}
   function automatic logic [10:0] presc_step(input logic [9:0] cnt, input logic [9:0] lim, input logic in);
      if (!in) begin
         return {1'b0, cnt};
      end
      if (cnt >= lim) begin
         return {1'b1, DIV_RESET};
      end
      return {1'b0, 10'(cnt + 10'h001)};
   endfunction : presc_step

   logic [7:0] rc_acc_q, rc_acc_d;
   logic       rc_tick_q, rc_tick_d;
   logic       ext_prev_q;
   logic       ext_tick;
   logic [7:0] mon_cnt_q, mon_cnt_d;
   logic       fail_lock_q, fail_lock_d;
   logic       fail_pulse;
   logic       want_ext;
   logic [9:0] ahb_cnt_q, ahb_cnt_d, apb2_cnt_q, apb2_cnt_d, apb1_cnt_q, apb1_cnt_d;
   logic       ahb_tick_d, apb2_tick_d, apb1_tick_d;
   logic [8:0] hold_q, hold_d;
   logic       core_rst_d;
   logic       pll_prev_q, det_prev_q;
   csu_flags_t flags_d, set_ev, ie_mask;
   logic       irq_d;

   // rc oscillator as a fractional tick stream at 8 MHz
   always_comb begin
      rc_tick_d = 1'b0;
      rc_acc_d  = 8'(rc_acc_q + RC_STEP);
      if (rc_acc_q >= 8'(RC_WRAP - RC_STEP)) begin
         rc_acc_d  = 8'(rc_acc_q + RC_STEP - RC_WRAP);
         rc_tick_d = 1'b1;
      end
   end

   assign ext_tick = ext_clk_in & ~ext_prev_q;
   assign want_ext = cfg.ext_req & ~fail_lock_q;

   // missing-edge monitor; lock holds the fallback until software drops its request
   always_comb begin
      fail_pulse  = 1'b0;
      mon_cnt_d   = 8'h00;
      fail_lock_d = fail_lock_q & cfg.ext_req;
      if (want_ext && !ext_tick) begin
         mon_cnt_d = 8'(mon_cnt_q + 8'h01);
         if (mon_cnt_q >= MON_LIMIT) begin
            fail_pulse  = 1'b1;
            fail_lock_d = 1'b1;
            mon_cnt_d   = 8'h00;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rc_acc_q    <= 8'h00;
         rc_tick_q   <= 1'b0;
         ext_prev_q  <= 1'b0;
         mon_cnt_q   <= 8'h00;
         fail_lock_q <= 1'b0;
      end else begin
         rc_acc_q    <= rc_acc_d;
         rc_tick_q   <= rc_tick_d;
         ext_prev_q  <= ext_clk_in;
         mon_cnt_q   <= mon_cnt_d;
         fail_lock_q <= fail_lock_d;
      end
   end

   csu_clk_switch u_switch (
      .clock      (clock),
      .rst        (rst),
      .rc_tick    (rc_tick_q),
      .ext_tick   (ext_tick),
      .want_ext   (want_ext),
      .sel_ext_q  (sel_ext_q),
      .sys_tick_q (sys_tick_q)
   );

   // prescaler chain: sources never exceed 24 MHz, so every domain stays at or below it
   always_comb begin
      {ahb_tick_d, ahb_cnt_d}   = presc_step(ahb_cnt_q, csu_div_limit(cfg.ahb_div), sys_tick_q);
      {apb2_tick_d, apb2_cnt_d} = presc_step(apb2_cnt_q,
                                             csu_div_limit({cfg.apb2_div[2], 1'b0, cfg.apb2_div[1:0]}),
                                             ahb_tick_q);
      {apb1_tick_d, apb1_cnt_d} = presc_step(apb1_cnt_q,
                                             csu_div_limit({cfg.apb1_div[2], 1'b0, cfg.apb1_div[1:0]}),
                                             ahb_tick_q);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ahb_cnt_q   <= DIV_RESET;
         apb2_cnt_q  <= DIV_RESET;
         apb1_cnt_q  <= DIV_RESET;
         ahb_tick_q  <= 1'b0;
         apb2_tick_q <= 1'b0;
         apb1_tick_q <= 1'b0;
      end else begin
         ahb_cnt_q   <= ahb_cnt_d;
         apb2_cnt_q  <= apb2_cnt_d;
         apb1_cnt_q  <= apb1_cnt_d;
         ahb_tick_q  <= ahb_tick_d;
         apb2_tick_q <= apb2_tick_d;
         apb1_tick_q <= apb1_tick_d;
      end
   end

   // boot pins caught on the first edge after reset release
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         boot_src_q <= BOOT_FLASH;
         boot_vld_q <= 1'b0;
      end else if (!boot_vld_q) begin
         boot_src_q <= csu_boot_decode(boot_pins);
         boot_vld_q <= 1'b1;
      end
   end

   // supply supervisor: hold while low, then stretch
   always_comb begin
      hold_d     = 9'h000;
      core_rst_d = CORE_RST_ON;
      if (supply_ok) begin
         if (hold_q >= HOLD_LIMIT) begin
            hold_d     = hold_q;
            core_rst_d = 1'b0;
         end else begin
            hold_d = 9'(hold_q + 9'h001);
         end
      end
   end

   // sticky flags: a new event wins over a clear in the same cycle
   always_comb begin
      set_ev.css_fail = fail_pulse;
      set_ev.pll_rdy  = pll_lock & ~pll_prev_q;
      set_ev.pll_lost = ~pll_lock & pll_prev_q;
      set_ev.det_fall = below_thr & ~det_prev_q;
      set_ev.det_rise = ~below_thr & det_prev_q;
      ie_mask         = {cfg.css_ie, cfg.pll_ie, cfg.pll_ie, cfg.det_fall_ie, cfg.det_rise_ie};
      flags_d         = set_ev | (flags_q & ~clr);
      irq_d           = |(flags_d & ie_mask);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hold_q     <= 9'h000;
         core_rst_q <= CORE_RST_ON;
         pll_prev_q <= 1'b0;
         det_prev_q <= 1'b0;
         flags_q    <= '0;
         irq_q      <= 1'b0;
      end else begin
         hold_q     <= hold_d;
         core_rst_q <= core_rst_d;
         pll_prev_q <= pll_lock;
         det_prev_q <= below_thr;
         flags_q    <= flags_d;
         irq_q      <= irq_d;
      end
   end

   a_rc_after_reset: assert property (@(posedge clock) disable iff (rst)
      $fell(rst) |-> !sel_ext_q ##1 !sel_ext_q)
      else $error("rc source not selected after reset");

   a_fail_falls_back: assert property (@(posedge clock) disable iff (rst)
      fail_pulse |-> ##[1:80] !sel_ext_q)
      else $error("no fallback after clock failure");

   a_fail_irq_on: assert property (@(posedge clock) disable iff (rst)
      (fail_pulse && cfg.css_ie) |=> (irq_q && flags_q.css_fail))
      else $error("clock failure interrupt missing");

   a_irq_masked: assert property (@(posedge clock) disable iff (rst)
      (ie_mask == '0) |=> !irq_q)
      else $error("interrupt raised with all enables clear");

   a_pll_events: assert property (@(posedge clock) disable iff (rst)
      ($rose(pll_lock) |=> flags_q.pll_rdy) and ($fell(pll_lock) |=> flags_q.pll_lost))
      else $error("pll lock event not flagged");

   a_ahb_rate: assert property (@(posedge clock) disable iff (rst)
      ahb_tick_q |=> !ahb_tick_q [*8])
      else $error("ahb domain above its maximum rate");

   a_apb_follow: assert property (@(posedge clock) disable iff (rst)
      (apb1_tick_q || apb2_tick_q) |-> $past(ahb_tick_q))
      else $error("apb tick without an ahb tick");

   a_boot_capture: assert property (@(posedge clock) disable iff (rst)
      $rose(boot_vld_q) |-> boot_src_q == csu_boot_decode($past(boot_pins)))
      else $error("boot source does not match pins");

   a_supply_hold: assert property (@(posedge clock) disable iff (rst)
      !supply_ok |=> core_rst_q)
      else $error("core out of reset with low supply");

   a_hold_stretch: assert property (@(posedge clock) disable iff (rst)
      $rose(supply_ok) |=> core_rst_q [*8])
      else $error("core reset released too early");

   a_detector_flags: assert property (@(posedge clock) disable iff (rst)
      ($rose(below_thr) |=> flags_q.det_fall) and ($fell(below_thr) |=> flags_q.det_rise))
      else $error("supply detector crossing not flagged");
endmodule : csu_top

// ===== tb/csu_top_tb.sv
// self-checking bench of the clock startup supervisor top level
// assumes the bench alone drives every input; inputs change 1 ns after the rising edge
`timescale 1ns/100ps
module csu_top_tb;
   import csu_pkg::*;
   logic       clock, rst, ext_clk_in, pll_lock, supply_ok, below_thr, ext_en;
   logic [1:0] boot_pins;
   csu_cfg_t   cfg;
   csu_flags_t clr, flags_q;
   logic       sys_tick_q, ahb_tick_q, apb2_tick_q, apb1_tick_q, sel_ext_q, boot_vld_q, core_rst_q, irq_q;
   csu_boot_t  boot_src_q;
   int         n_mismatch, comparisons, gap, seen;

   csu_top dut_u (.clock(clock), .rst(rst), .cfg(cfg), .clr(clr), .ext_clk_in(ext_clk_in),
      .pll_lock(pll_lock), .supply_ok(supply_ok), .below_thr(below_thr), .boot_pins(boot_pins),
      .sys_tick_q(sys_tick_q), .ahb_tick_q(ahb_tick_q), .apb2_tick_q(apb2_tick_q),
      .apb1_tick_q(apb1_tick_q), .sel_ext_q(sel_ext_q), .boot_src_q(boot_src_q),
      .boot_vld_q(boot_vld_q), .core_rst_q(core_rst_q), .flags_q(flags_q), .irq_q(irq_q));

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // 12.5 MHz external clock; stopping it leaves the level stuck, as a dead oscillator would
   initial begin
      ext_clk_in = 1'b0;
      forever begin
         repeat (10) @(posedge clock);
         #1;
         if (ext_en) ext_clk_in = ~ext_clk_in;
      end
   end

   // no system tick may come closer than one 24 MHz period
   always @(posedge clock) begin
      if (rst) begin
         gap = 0;
         seen = 0;
      end else if (sys_tick_q) begin
         if (seen != 0) comparisons++;
         if (seen != 0 && gap < 10) begin
            $display("[ERR] sys_tick_gap expected >=10 seen %0d", gap);
            n_mismatch++;
         end
         gap = 1;
         seen = 1;
      end else gap++;
   end

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (exp !== got) begin
         $display("[ERR] %s expected %0h seen %0h", name, exp, got);
         n_mismatch++;
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : step

   // waits for a watched output to reach a level; returns cycles taken
   task automatic wait_for(input int sel, input logic val, input int max, output int n);
      logic v;
      for (n = 1; n <= max; n++) begin
         step(1);
         case (sel)
            0: v = sel_ext_q;
            1: v = core_rst_q;
            2: v = flags_q.css_fail;
            default: v = sys_tick_q;
         endcase
         if (v === val) return;
      end
      $display("[ERR] wait_for %0d expected %0b seen timeout", sel, val);
      n_mismatch++;
      report_and_stop();
   endtask : wait_for

   task automatic do_reset(input logic [1:0] pins);
      step(1);
      rst = 1'b1;
      boot_pins = pins;
      step(2);
      chk("rst_sel_ext", 1'b0, sel_ext_q);
      chk("rst_core_rst", 1'b1, core_rst_q);
      chk("rst_boot_vld", 1'b0, boot_vld_q);
      rst = 1'b0;
   endtask : do_reset

   task automatic boot_scan();
      csu_boot_t exp_src [4] = '{BOOT_FLASH, BOOT_SYSMEM, BOOT_FLASH, BOOT_SRAM};
      for (int p = 0; p < 4; p++) begin
         do_reset(2'(p));
         step(2);
         chk("boot_vld", 1'b1, boot_vld_q);
         chk("boot_src", exp_src[p], boot_src_q);
         boot_pins = ~boot_pins;
         step(3);
         chk("boot_hold", exp_src[p], boot_src_q);
      end
   endtask : boot_scan

   task automatic supply_scan();
      int n;
      supply_ok = 1'b0;
      step(3);
      chk("low_supply_rst", 1'b1, core_rst_q);
      supply_ok = 1'b1;
      step(240);
      chk("hold_rst", 1'b1, core_rst_q);
      wait_for(1, 1'b0, 30, n);
      supply_ok = 1'b0;
      step(1);
      supply_ok = 1'b1;
      wait_for(1, 1'b1, 3, n);
   endtask : supply_scan

   task automatic ext_fail(input logic ie);
      int n;
      cfg.css_ie = ie;
      ext_en = 1'b1;
      cfg.ext_req = 1'b1;
      wait_for(0, 1'b1, 100, n);
      wait_for(3, 1'b1, 30, n);
      wait_for(3, 1'b1, 30, n);
      chk("ext_tick_gap", 20, n);
      ext_en = 1'b0;
      step(100);
      chk("early_fail", 1'b0, flags_q.css_fail);
      wait_for(2, 1'b1, 100, n);
      step(1);
      chk("fail_irq", ie, irq_q);
      wait_for(0, 1'b0, 100, n);
      ext_en = 1'b1;
      step(100);
      chk("fail_lock", 1'b0, sel_ext_q);
      clr.css_fail = 1'b1;
      step(1);
      clr = '0;
      step(2);
      chk("css_clr", 1'b0, flags_q.css_fail);
      chk("css_irq_clr", 1'b0, irq_q);
      cfg.ext_req = 1'b0;
      step(1);
   endtask : ext_fail

   task automatic ext_release();
      int n;
      cfg.ext_req = 1'b1;
      wait_for(0, 1'b1, 100, n);
      cfg.ext_req = 1'b0;
      wait_for(0, 1'b0, 100, n);
      step(100);
      chk("rc_back", 1'b0, sel_ext_q);
      ext_en = 1'b0;
   endtask : ext_release

   task automatic presc_scan();
      logic ps, pa;
      int   na, n2, n1, t;
      ps = sys_tick_q;
      pa = ahb_tick_q;
      na = 0;
      for (int i = 0; i < 300; i++) begin
         step(1);
         if (ps !== ahb_tick_q) chk("ahb_div1", ps, ahb_tick_q);
         if (pa !== apb2_tick_q) chk("apb2_div1", pa, apb2_tick_q);
         na += int'(ahb_tick_q);
         ps = sys_tick_q;
         pa = ahb_tick_q;
      end
      chk("ahb_seen", 1'b1, na >= 9);
      {cfg.ahb_div, cfg.apb2_div, cfg.apb1_div} = {4'h8, 3'h4, 3'h5};
      na = 0;
      n2 = 0;
      n1 = 0;
      t = 0;
      for (int k = 0; k < 2100 && t < 64; k++) begin
         step(1);
         if (sys_tick_q) t++;
         na += int'(ahb_tick_q);
         n2 += int'(apb2_tick_q);
         n1 += int'(apb1_tick_q);
      end
      chk("presc_sys_ticks", 64, t);
      if (t < 64) report_and_stop();
      chk("ahb_div2", 1'b1, na >= 31 && na <= 33);
      chk("apb2_div2", 1'b1, n2 >= 15 && n2 <= 17);
      chk("apb1_div4", 1'b1, n1 >= 7 && n1 <= 9);
   endtask : presc_scan

   task automatic event_scan();
      // rows: pll rise, pll fall, detector fall below, detector rise above
      int   bitpos [4] = '{3, 2, 1, 0};
      logic exp_irq [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
      int   n;
      cfg.pll_ie = 1'b1;
      cfg.det_fall_ie = 1'b1;
      for (int e = 0; e < 4; e++) begin
         if (e < 2) pll_lock = ~pll_lock;
         else below_thr = ~below_thr;
         for (n = 0; n < 4 && flags_q[bitpos[e]] !== 1'b1; n++) step(1);
         chk("event_flag", 1'b1, flags_q[bitpos[e]]);
         if (flags_q[bitpos[e]] !== 1'b1) report_and_stop();
         chk("event_irq", exp_irq[e], irq_q);
         clr = csu_flags_t'(5'h01 << bitpos[e]);
         step(1);
         clr = '0;
         step(2);
         chk("event_clr", 5'h00, flags_q);
      end
   endtask : event_scan

   initial begin
      n_mismatch = 0;
      comparisons = 0;
      rst = 1'b1;
      cfg = '0;
      clr = '0;
      ext_en = 1'b0;
      pll_lock = 1'b0;
      supply_ok = 1'b1;
      below_thr = 1'b0;
      boot_pins = 2'h0;
      repeat (12) @(posedge clock);
      #1;
      rst = 1'b0;
      boot_scan();
      supply_scan();
      ext_fail(1'b1);
      ext_fail(1'b0);
      ext_release();
      presc_scan();
      event_scan();
      ext_en = 1'b1;
      cfg.ext_req = 1'b1;
      step(100);
      do_reset(2'h0);
      step(2);
      chk("rst_rc", 1'b0, sel_ext_q);
      report_and_stop();
   end
endmodule : csu_top_tb
